/* File: inc/acs_pkg.sv */
// constants, types and register map of the conversion sequencer
package acs_pkg;

   // ----------------------------------------------------------------
   // clock and bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_KHZ = 10000;
   localparam int unsigned ADDR_W       = 10;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned TICK_W       = 6;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_RESULT     = 8'h1E;
   localparam logic [7:0] IDX_CONTROL    = 8'h1F;
   localparam logic [7:0] IDX_PIN_CONFIG = 8'h9F;
   localparam logic [7:0] IDX_INT_STATUS = 8'hA0;
   localparam logic [7:0] IDX_INT_MASK   = 8'hA1;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] CONTROL_RST    = 8'h00;
   localparam logic [7:0] RESULT_RST     = 8'h00;
   localparam logic [2:0] PIN_CONFIG_RST = 3'h0;
   localparam logic       INT_FLAG_RST   = 1'b0;
   localparam logic       INT_MASK_RST   = 1'b0;
   localparam int unsigned CTRL_ON_BIT   = 0;
   localparam int unsigned CTRL_GO_BIT   = 2;
   localparam int unsigned STAT_DONE_BIT = 0;
   localparam logic [7:0] SAR_MSB        = 8'h80;

   // ----------------------------------------------------------------
   // conversion clock selection and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] CLK_SEL_OSC2  = 2'h0;
   localparam logic [1:0] CLK_SEL_OSC8  = 2'h1;
   localparam logic [1:0] CLK_SEL_OSC32 = 2'h2;
   localparam logic [1:0] CLK_SEL_RC    = 2'h3;
   // half bit periods, in oscillator cycles
   localparam logic [TICK_W-1:0] HALF_TAD_OSC2  = 6'h01;
   localparam logic [TICK_W-1:0] HALF_TAD_OSC8  = 6'h04;
   localparam logic [TICK_W-1:0] HALF_TAD_OSC32 = 6'h10;
   // typical rc bit period in ns
   localparam int unsigned RC_TAD_NS   = 4000;
   localparam logic [TICK_W-1:0] HALF_TAD_RC =
      TICK_W'((RC_TAD_NS * CLK_FREQ_KHZ) / 2000000);
   // one instruction cycle in ns, rounded up to core cycles
   localparam int unsigned INSTR_CYCLE_NS = 400;
   localparam logic [2:0] INSTR_CYC =
      3'((INSTR_CYCLE_NS * CLK_FREQ_KHZ + 999999) / 1000000);
   // 9.5 and 2 bit periods, counted in half periods
   localparam logic [4:0] CONV_HALF_TADS    = 5'h13;
   localparam logic [4:0] HOLDOFF_HALF_TADS = 5'h04;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] conv_clock_select;
      logic [2:0] input_channel_select;
      logic       go_done;
      logic       unused;
      logic       converter_on;
   } acs_ctrl_t;

   typedef struct packed {
      logic       power;
      logic       acquire;
      logic [2:0] channel;
      logic [7:0] trial;
   } acs_analog_t;

   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_START_DLY,
      ACS_CONVERT,
      ACS_HOLDOFF
   } acs_state_t;

endpackage

/* File: rtl/acs_tad_gen.sv */
// half bit period tick generator for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             srst,
   // control
   input  wire logic             run,
   input  wire logic [1:0]       clk_sel,
   // tick out
   output logic                  half_tick
);
   import acs_pkg::*;

   logic [TICK_W-1:0] count;
   logic [TICK_W-1:0] half_len;

   // ----------------------------------------------------------------
   // bit period select
   // ----------------------------------------------------------------
   // half period per select code
   always_comb
   begin
      unique case (clk_sel)
         CLK_SEL_OSC2:  half_len = HALF_TAD_OSC2;
         CLK_SEL_OSC8:  half_len = HALF_TAD_OSC8;
         CLK_SEL_OSC32: half_len = HALF_TAD_OSC32;
         CLK_SEL_RC:    half_len = HALF_TAD_RC;
      endcase
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // restarts on every run, so the first tick is a full half period away
   always_ff @(posedge ref_clk)
   begin
      if (srst || !run)
         count <= '0;
      else if (half_tick)
         count <= '0;
      else
         count <= count + 1'b1;
   end

   assign half_tick = run && (count == half_len - 1'b1);

endmodule
`default_nettype wire

/* File: rtl/acs_sequencer.sv */
// conversion sequencer: register slave, sar timing, interrupt
//
// Contract
// - two-bit clock select picks 2, 8, 32 oscillator periods or rc clock.
// - three-bit field in control bits 5..3 selects analog channel 0..7.
// - on completion go clears and the converter interrupt flag sets.
// - control bit 0 enables the module; zero shuts it off.
// - a conversion lasts nine and a half bit periods.
// - two bit periods pass after completion before acquisition resumes.
// - rc clock modelled with typical 4 us bit period.
// - clearing go mid-conversion aborts, keeps result, reacquires after 2 periods.
// - rc clock source delays one instruction cycle before converting.
// - compare unit trigger starts a conversion only while enabled.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         srst,
   // avalon-mm slave
   input  wire logic [acs_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [acs_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output logic      [acs_pkg::DATA_W-1:0]   avs_readdata,
   output logic                              avs_waitrequest,
   // compare unit special event
   input  wire logic                         special_event_trigger,
   // analog converter core
   input  wire logic                         cmp_high,
   output acs_pkg::acs_analog_t              analog,
   output logic      [2:0]                   pin_config,
   // interrupt
   output logic                              converter_irq
);
   import acs_pkg::*;

   acs_state_t  state;
   acs_ctrl_t   ctrl;
   logic [7:0]  conversion_result;
   logic [7:0]  sar;
   logic [7:0]  bit_ptr;
   logic [4:0]  half_cnt;
   logic [2:0]  dly_cnt;
   logic        converter_int_flag;
   logic        converter_int_enable;
   logic        bus_ack;
   logic        bus_req;
   logic        bus_take;
   logic        reg_wr;
   logic        ctrl_wr;
   logic [7:0]  idx;
   logic        idx_ok;
   logic [7:0]  rd_mux;
   logic        half_tick;
   logic        run_tad;
   logic        busy;
   logic        sw_start;
   logic        trig_start;
   logic        sw_abort;
   logic        done_pulse;
   logic        bit_decide;

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, then the request is taken
   // ----------------------------------------------------------------
   assign bus_req         = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !bus_ack;
   assign bus_take        = bus_req && bus_ack;
   assign idx             = avs_address[9:2];
   assign idx_ok          = (avs_address[1:0] == 2'h0);
   assign reg_wr          = bus_take && avs_write && avs_byteenable[0] && idx_ok;
   assign ctrl_wr         = reg_wr && (idx == IDX_CONTROL);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         bus_ack <= 1'b0;
      else
         bus_ack <= bus_req && !bus_ack;
   end

   always_comb
   begin
      rd_mux = 8'h00;
      if (idx_ok)
      begin
         unique case (idx)
            IDX_CONTROL:    rd_mux = {ctrl[7:2], 1'b0, ctrl.converter_on};
            IDX_RESULT:     rd_mux = conversion_result;
            IDX_PIN_CONFIG: rd_mux = {5'h00, pin_config};
            IDX_INT_STATUS: rd_mux = {7'h00, converter_int_flag};
            IDX_INT_MASK:   rd_mux = {7'h00, converter_int_enable};
            default:        rd_mux = 8'h00;
         endcase
      end
   end

   // data captured in the wait cycle, stands at the taking edge
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         avs_readdata <= '0;
      else if (avs_read && !bus_ack)
         avs_readdata <= {24'h000000, rd_mux};
   end

   // ----------------------------------------------------------------
   // start, abort and completion events
   // ----------------------------------------------------------------
   assign busy = (state == ACS_START_DLY) || (state == ACS_CONVERT);
   // go write starts only with the module already on
   assign sw_start   = ctrl_wr && avs_writedata[CTRL_GO_BIT] && ctrl.converter_on && !ctrl.go_done;
   assign trig_start = special_event_trigger && ctrl.converter_on && !ctrl.go_done;
   assign sw_abort   = ctrl_wr && !avs_writedata[CTRL_GO_BIT] && busy;
   assign run_tad    = (state == ACS_CONVERT) || (state == ACS_HOLDOFF);
   assign bit_decide = (state == ACS_CONVERT) && half_tick && half_cnt[0] && (bit_ptr != 8'h00);
   // done on the nineteenth half period
   assign done_pulse = (state == ACS_CONVERT) && half_tick && (half_cnt == CONV_HALF_TADS - 1'b1)
                       && !sw_abort && ctrl.converter_on;

   acs_tad_gen u_tad (
      .ref_clk   (ref_clk),
      .srst      (srst),
      // abort restarts the tick so the holdoff runs two full bit periods
      .run       (run_tad && !sw_abort),
      .clk_sel   (ctrl.conv_clock_select),
      .half_tick (half_tick)
   );

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         ctrl <= acs_ctrl_t'(CONTROL_RST);
      else
      begin
         if (ctrl_wr)
         begin
            ctrl.conv_clock_select    <= avs_writedata[7:6];
            ctrl.input_channel_select <= avs_writedata[5:3];
            ctrl.converter_on         <= avs_writedata[CTRL_ON_BIT];
         end
         ctrl.unused <= 1'b0;
         if (!ctrl.converter_on || done_pulse || sw_abort)
            ctrl.go_done <= 1'b0;
         else if (sw_start || trig_start)
            ctrl.go_done <= 1'b1;
         else if (ctrl_wr && !avs_writedata[CTRL_GO_BIT])
            ctrl.go_done <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         state <= ACS_IDLE;
      else if (!ctrl.converter_on)
         state <= ACS_IDLE;
      else
      begin
         unique case (state)
            ACS_IDLE:
               if (ctrl.go_done)
                  // rc source waits an instruction cycle
                  state <= (ctrl.conv_clock_select == CLK_SEL_RC) ? ACS_START_DLY : ACS_CONVERT;
            ACS_START_DLY:
               if (sw_abort)
                  state <= ACS_HOLDOFF;
               else if (dly_cnt == INSTR_CYC - 1'b1)
                  state <= ACS_CONVERT;
            ACS_CONVERT:
               if (sw_abort || done_pulse)
                  state <= ACS_HOLDOFF;
            ACS_HOLDOFF:
               if (half_tick && half_cnt == HOLDOFF_HALF_TADS - 1'b1)
                  state <= ACS_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || state != ACS_START_DLY)
         dly_cnt <= 3'h0;
      else
         dly_cnt <= dly_cnt + 1'b1;
   end

   // half period count, restarted on each phase change
   always_ff @(posedge ref_clk)
   begin
      if (srst || !run_tad || sw_abort || done_pulse)
         half_cnt <= 5'h00;
      else if (half_tick)
         half_cnt <= half_cnt + 1'b1;
   end

   // ----------------------------------------------------------------
   // successive approximation
   // ----------------------------------------------------------------
   // msb first, one bit per period
   always_ff @(posedge ref_clk)
   begin
      if (srst || state != ACS_CONVERT)
      begin
         sar     <= 8'h00;
         bit_ptr <= SAR_MSB;
      end
      else if (bit_decide)
      begin
         if (cmp_high)
            sar <= sar | bit_ptr;
         bit_ptr <= bit_ptr >> 1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         conversion_result <= RESULT_RST;
      else if (done_pulse)
         conversion_result <= sar;
      else if (reg_wr && idx == IDX_RESULT)
         conversion_result <= avs_writedata[7:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         pin_config <= PIN_CONFIG_RST;
      else if (reg_wr && idx == IDX_PIN_CONFIG)
         pin_config <= avs_writedata[2:0];
   end

   // power, acquire, channel select and trial value to the analog core
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         analog <= '0;
      else
      begin
         analog.power   <= ctrl.converter_on;
         analog.acquire <= ctrl.converter_on && state == ACS_IDLE;
         analog.channel <= ctrl.input_channel_select;
         analog.trial   <= sar | bit_ptr;
      end
   end

   // ----------------------------------------------------------------
   // interrupt: sticky flag, read clears, set wins
   // ----------------------------------------------------------------
   // completion raises the flag
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         converter_int_flag <= INT_FLAG_RST;
      else if (done_pulse)
         converter_int_flag <= 1'b1;
      else if (bus_take && avs_read && idx_ok && idx == IDX_INT_STATUS)
         converter_int_flag <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         converter_int_enable <= INT_MASK_RST;
      else if (reg_wr && idx == IDX_INT_MASK)
         converter_int_enable <= avs_writedata[STAT_DONE_BIT];
   end

   assign converter_irq = converter_int_flag && converter_int_enable;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   go_start_a: assert property (sw_start && !sw_abort |=> ctrl.go_done || !ctrl.converter_on)
      else $error("go did not set on start");
   done_flag_a: assert property (done_pulse |=> !ctrl.go_done && converter_int_flag)
      else $error("completion did not clear go and set flag");
   off_idle_a: assert property (!ctrl.converter_on |=> state == ACS_IDLE && !ctrl.go_done)
      else $error("disabled module still active");
   conv_len_a: assert property (done_pulse |-> half_cnt == 5'h12 && bit_ptr == 8'h00)
      else $error("conversion length wrong");
   holdoff_a: assert property (done_pulse |=> state == ACS_HOLDOFF && half_cnt == 5'h00)
      else $error("no holdoff after completion");
   rc_delay_a: assert property ($rose(state == ACS_START_DLY) |-> dly_cnt == 3'h0 ##1
                                (state == ACS_START_DLY || !ctrl.go_done))
      else $error("rc start delay too short");
   abort_keep_a: assert property (sw_abort && avs_writedata[CTRL_ON_BIT]
                                  |=> $stable(conversion_result) && state == ACS_HOLDOFF)
      else $error("abort changed result");
   trig_ignore_a: assert property (special_event_trigger && !ctrl.converter_on && !ctrl.go_done
                                   |=> !ctrl.go_done)
      else $error("trigger accepted while disabled");
   msb_first_a: assert property ($rose(state == ACS_CONVERT) |-> bit_ptr == SAR_MSB && sar == 8'h00)
      else $error("conversion not starting at msb");
   bit1_zero_a: assert property (avs_read && bus_ack && idx_ok && idx == IDX_CONTROL
                                 |-> avs_readdata[1] == 1'b0)
      else $error("control bit 1 read nonzero");

endmodule
`default_nettype wire

/* File: test/acs_analog_model.sv */
// behavioural analog core answering the sar comparator
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
   // clock
   input  wire logic                 ref_clk,
   // sequencer side
   input  wire acs_pkg::acs_analog_t analog,
   input  wire logic [7:0]           level,
   // comparator
   output logic                      cmp_high
);
   import acs_pkg::*;
   logic [7:0] held;
   logic       junk = 1'b0;
   // ---------------------------------------------------------
   // sample and hold
   // ---------------------------------------------------------
   // hold tracks input while acquire is high
   always_ff @(posedge ref_clk)
   begin
      if (analog.acquire)
      begin
         held <= level;
      end
      junk <= ~junk;
   end
   // unpowered comparator means nothing, so it wanders
   assign cmp_high = analog.power ? (held >= analog.trial) : junk;
endmodule
`default_nettype wire

/* File: test/acs_sequencer_bench.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench;
   import acs_pkg::*;
   logic              ref_clk = 1'b0;
   logic              srst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0]        avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic              trig = 1'b0;
   logic              cmp_high;
   acs_analog_t       analog;
   logic [2:0]        pin_config;
   logic              converter_irq;
   logic [7:0]        level = 8'h00;
   logic [7:0]        rd;
   int                n_errors = 0;
   int                tests_run = 0;
   int                k;

   always #50 ref_clk = ~ref_clk;

   acs_sequencer dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .special_event_trigger(trig),
      .cmp_high(cmp_high), .analog(analog), .pin_config(pin_config), .converter_irq(converter_irq));
   acs_analog_model core (.ref_clk(ref_clk), .analog(analog), .level(level), .cmp_high(cmp_high));

   // ---------------------------------------------------------
   // reporting
   // ---------------------------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic hang(input string what);
      n_errors++;
      $display("mismatch %s expected response seen timeout", what);
      wrap_up();
   endtask

   // ---------------------------------------------------------
   // bus access
   // ---------------------------------------------------------
   // request held until the rising edge that sees waitrequest low; data taken there
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
      int i;
      @(posedge ref_clk);
      avs_address    <= {idx, 2'b00};
      avs_writedata  <= {24'h0, wd};
      avs_byteenable <= be;
      avs_read       <= ~wr;
      avs_write      <= wr;
      for (i = 0; i < 20; i++)
      begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 20)
         hang("waitrequest");
      rd = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, 4'hF);
      chk(what, exp, rd);
   endtask

   function automatic logic [7:0] ctl(input logic [1:0] s, input logic [2:0] c, input logic g, input logic on);
      return {s, c, g, 1'b0, on};
   endfunction

   // cycles until sampling resumes, against two bit periods
   task automatic acq_wait(input int h);
      int m;
      m = 0;
      while (analog.acquire !== 1'b1 && m < 1000)
      begin
         @(negedge ref_clk);
         m++;
      end
      if (m == 1000)
         hang("acquire");
      chk("holdoff", 8'h01, {7'h0, m >= int'(HOLDOFF_HALF_TADS) * h - 1 && m <= int'(HOLDOFF_HALF_TADS) * h + 4});
   endtask

   // ---------------------------------------------------------
   // one full conversion
   // ---------------------------------------------------------
   task automatic convert(input logic [1:0] s, input logic [2:0] c, input logic [7:0] v);
      int h, n, lo;
      h = (s == CLK_SEL_OSC2) ? int'(HALF_TAD_OSC2) : (s == CLK_SEL_OSC8) ? int'(HALF_TAD_OSC8) :
          (s == CLK_SEL_OSC32) ? int'(HALF_TAD_OSC32) : int'(HALF_TAD_RC);
      lo = int'(CONV_HALF_TADS) * h + ((s == CLK_SEL_RC) ? int'(INSTR_CYC) : 0);
      level <= v;
      bus(1'b1, IDX_CONTROL, ctl(s, c, 1'b0, 1'b1), 4'h1);
      repeat (100) @(posedge ref_clk);
      chk("acquire", 8'h01, {7'h0, analog.acquire});
      bus(1'b1, IDX_CONTROL, ctl(s, c, 1'b1, 1'b1), 4'h1);
      n = 0;
      while (converter_irq !== 1'b1 && n < 1000)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 1000)
         hang("conversion");
      chk("conv time", 8'h01, {7'h0, n >= lo && n <= lo + 3});
      acq_wait(h);
      rchk("result", IDX_RESULT, v);
      rchk("control", IDX_CONTROL, ctl(s, c, 1'b0, 1'b1));
      rchk("flag", IDX_INT_STATUS, 8'h01);
      // read clear lands at the taking edge; look once it has settled
      @(negedge ref_clk);
      chk("irq", 8'h00, {7'h0, converter_irq});
      rchk("flag clr", IDX_INT_STATUS, 8'h00);
      $display("test conversion sel %0d done", s);
   endtask

   task automatic pulse();
      @(posedge ref_clk);
      trig <= 1'b1;
      @(posedge ref_clk);
      trig <= 1'b0;
   endtask

   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      chk("analog rst", 8'h00, {3'h0, analog[12:8]});
      rchk("control rst", IDX_CONTROL, CONTROL_RST);
      rchk("result rst", IDX_RESULT, RESULT_RST);
      rchk("pins rst", IDX_PIN_CONFIG, 8'h00);
      rchk("mask rst", IDX_INT_MASK, 8'h00);
      rchk("unmapped", 8'h10, 8'h00);
      bus(1'b1, IDX_PIN_CONFIG, 8'hFF, 4'h1);
      rchk("pins", IDX_PIN_CONFIG, 8'h07);
      chk("pin port", 8'h07, {5'h0, pin_config});
      bus(1'b1, IDX_CONTROL, 8'hFE, 4'h1);
      rchk("go off", IDX_CONTROL, 8'hF8);
      chk("power off", 8'h00, {7'h0, analog.power});
      bus(1'b1, IDX_CONTROL, 8'h01, 4'h0);
      rchk("lane off", IDX_CONTROL, 8'hF8);
      $display("test registers done");
      for (k = 0; k < 8; k++)
      begin
         bus(1'b1, IDX_CONTROL, ctl(2'h0, k[2:0], 1'b0, 1'b1), 4'h1);
         repeat (2) @(posedge ref_clk);
         chk("channel", {5'h0, k[2:0]}, {5'h0, analog.channel});
      end
      $display("test channels done");
      bus(1'b1, IDX_INT_MASK, 8'h01, 4'h1);
      convert(CLK_SEL_OSC2, 3'h0, 8'hA5);
      convert(CLK_SEL_OSC8, 3'h7, 8'h00);
      // slow selects only keep the minimum bit period; bus stays quiet while rc converts
      convert(CLK_SEL_OSC32, 3'h3, 8'hFF);
      convert(CLK_SEL_RC, 3'h5, 8'h5A);
      level <= 8'h3C;
      bus(1'b1, IDX_CONTROL, ctl(2'h2, 3'h4, 1'b1, 1'b1), 4'h1);
      repeat (100) @(posedge ref_clk);
      bus(1'b1, IDX_CONTROL, ctl(2'h2, 3'h4, 1'b0, 1'b1), 4'h1);
      acq_wait(int'(HALF_TAD_OSC32));
      repeat (250) @(posedge ref_clk);
      rchk("abort flag", IDX_INT_STATUS, 8'h00);
      rchk("abort result", IDX_RESULT, 8'h5A);
      $display("test abort done");
      bus(1'b1, IDX_CONTROL, ctl(2'h2, 3'h1, 1'b0, 1'b0), 4'h1);
      pulse();
      repeat (3) @(posedge ref_clk);
      rchk("trig off", IDX_CONTROL, ctl(2'h2, 3'h1, 1'b0, 1'b0));
      bus(1'b1, IDX_INT_MASK, 8'h00, 4'h1);
      bus(1'b1, IDX_CONTROL, ctl(2'h2, 3'h1, 1'b0, 1'b1), 4'h1);
      level <= 8'h81;
      repeat (100) @(posedge ref_clk);
      pulse();
      rchk("trig go", IDX_CONTROL, ctl(2'h2, 3'h1, 1'b1, 1'b1));
      k = 0;
      do
      begin
         bus(1'b0, IDX_CONTROL, 8'h00, 4'hF);
         k++;
      end
      while (rd[CTRL_GO_BIT] !== 1'b0 && k < 200);
      if (k == 200)
         hang("go clear");
      chk("irq masked", 8'h00, {7'h0, converter_irq});
      bus(1'b1, IDX_INT_MASK, 8'h01, 4'h1);
      @(posedge ref_clk);
      chk("irq unmasked", 8'h01, {7'h0, converter_irq});
      rchk("trig flag", IDX_INT_STATUS, 8'h01);
      rchk("trig result", IDX_RESULT, 8'h81);
      chk("irq clr", 8'h00, {7'h0, converter_irq});
      $display("test trigger done");
      wrap_up();
   end
endmodule
`default_nettype wire
